// ---- verilog/spo_core.sv ----
`timescale 1ns/1ps
`include "spo_params.svh"

module spo_core (
   input wire logic clk_sys, // System clock, 125 MHz.
   input wire logic reset, // Asynchronous reset, active high.
   input wire logic [`SPO_ADDR_W-1:0] reg_addr, // Register byte address.
   input wire logic reg_wr, // Write strobe, one cycle.
   input wire logic [31:0] reg_wdata, // Write data.
   input wire logic reg_rd, // Read strobe, one cycle.
   output spo_pkg::spo_word_t reg_rdata, // Read data, valid the cycle after reg_rd.
   input wire logic comm_evt, // One pulse per electrical commutation.
   input wire logic open_loop_active, // Motor is in open-loop drive.
   input wire logic closed_loop_active, // Motor is in closed-loop drive.
   input wire logic first_try, // Current startup is the first attempt.
   input wire logic motor_driven, // Motor is being driven.
   input wire logic [`SPO_THR_MV_W-1:0] bemf_mv, // Back-EMF magnitude in mV.
   output logic speed_pulse_output, // Speed feedback square wave.
   output logic [1:0] pulse_phase_select, // Live phase select field.
   output logic pulse_stop_active // High while output is halted on back-EMF.
);
   import spo_pkg::*;

   spo_word_t cfg_ff;
   spo_word_t rdata_ff;
   spo_word_t nxt_rdata;
   spo_state_e state_ff;
   spo_state_e nxt_state;
   logic out_ff;
   logic nxt_out;

   // ****************************************************************
   // Field decoding
   // ****************************************************************

   // Maps a threshold code to millivolts; unused codes fall back to the largest.
   function automatic logic [`SPO_THR_MV_W-1:0] thr_mv(input logic [2:0] code);
      logic [`SPO_THR_MV_W-1:0] mv;
      mv = `SPO_THR_CODE5_MV;
      unique case (code)
         3'h0: mv = `SPO_THR_CODE0_MV;
         3'h1: mv = `SPO_THR_CODE1_MV;
         3'h2: mv = `SPO_THR_CODE2_MV;
         3'h3: mv = `SPO_THR_CODE3_MV;
         3'h4: mv = `SPO_THR_CODE4_MV;
         3'h5: mv = `SPO_THR_CODE5_MV;
         3'h6: mv = `SPO_THR_CODE5_MV;
         3'h7: mv = `SPO_THR_CODE5_MV;
      endcase
      return mv;
   endfunction

   wire spo_phase_e phase_sel;
   wire logic [3:0] div_code;
   wire logic [3:0] div_ratio;
   wire logic stop_cfg;
   wire logic [2:0] thr_code;
   wire logic [`SPO_THR_MV_W-1:0] thr_value;

   assign phase_sel = spo_phase_e'(cfg_ff[`SPO_PHASE_MSB:`SPO_PHASE_LSB]);
   assign div_code = cfg_ff[`SPO_DIV_MSB:`SPO_DIV_LSB];
   assign stop_cfg = cfg_ff[`SPO_STOPCFG_BIT];
   assign thr_code = cfg_ff[`SPO_THR_MSB:`SPO_THR_LSB];
   assign thr_value = thr_mv(thr_code);

   // Code zero divides by three, every other code by its own value.
   assign div_ratio = (div_code == 4'h0) ? `SPO_DIV_ZERO_RATIO : div_code;

   // ****************************************************************
   // Register access
   // ****************************************************************

   wire logic cfg_hit;
   assign cfg_hit = (reg_addr == `SPO_CFG2_ADDR);

   // Unmapped addresses read as zero rather than aliasing the word.
   assign nxt_rdata = (reg_rd && cfg_hit) ? cfg_ff : 32'h0000_0000;

   // The whole word is stored, parity and the unused fields included, so
   // software reads back exactly what it wrote.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cfg_ff <= `SPO_CFG2_RESET;
      end else if (reg_wr && cfg_hit) begin
         cfg_ff <= reg_wdata;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rdata_ff <= 32'h0000_0000;
      end else if (reg_rd) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ****************************************************************
   // Phase gating
   // ****************************************************************

   // Open-loop pulses are allowed per phase code; an invalid code blocks all.
   wire logic open_ok;
   wire logic closed_ok;
   wire logic phase_ok;

   assign open_ok = (phase_sel == SPO_PHASE_BOTH)
      || ((phase_sel == SPO_PHASE_FIRST_TRY) && first_try);
   assign closed_ok = (phase_sel != SPO_PHASE_INVALID);
   assign phase_ok = (open_loop_active && open_ok) || (closed_loop_active && closed_ok);

   // ****************************************************************
   // Stop control
   // ****************************************************************

   // With stop bit clear, a drop below threshold halts the output until the
   // motor stops being driven or the stop bit is set; this avoids chatter near the threshold.
   wire logic below_thr;
   assign below_thr = (bemf_mv < thr_value);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         SPO_ST_IDLE: begin
            if (motor_driven) begin
               nxt_state = SPO_ST_RUN;
            end
         end
         SPO_ST_RUN: begin
            if (!motor_driven) begin
               nxt_state = SPO_ST_IDLE;
            end else if (!stop_cfg && below_thr) begin
               nxt_state = SPO_ST_HALTED;
            end
         end
         SPO_ST_HALTED: begin
            if (!motor_driven || stop_cfg) begin
               nxt_state = motor_driven ? SPO_ST_RUN : SPO_ST_IDLE;
            end
         end
         default: begin
            nxt_state = SPO_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_ff <= SPO_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ****************************************************************
   // Pulse generation
   // ****************************************************************

   wire logic emit_ok;
   wire logic div_tick;

   assign emit_ok = (state_ff == SPO_ST_RUN) && phase_ok;

   // The divider restarts whenever emission is blocked, so the first output
   // edge after a resume always spans a full divided period.
   spo_divider #(
      .DIV_W(4)
   ) u_div (
      .clk_sys(clk_sys),
      .reset(reset),
      .clear(!emit_ok),
      .evt(comm_evt),
      .ratio(div_ratio),
      .tick(div_tick)
   );

   // The output toggles once per divided group and rests low when blocked.
   assign nxt_out = !emit_ok ? 1'b0 : (div_tick ? !out_ff : out_ff);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         out_ff <= 1'b0;
      end else begin
         out_ff <= nxt_out;
      end
   end

   assign speed_pulse_output = out_ff;
   assign reg_rdata = rdata_ff;
   assign pulse_phase_select = cfg_ff[`SPO_PHASE_MSB:`SPO_PHASE_LSB];
   assign pulse_stop_active = (state_ff == SPO_ST_HALTED);

endmodule

// ---- shared/spo_params.svh ----
`ifndef SPO_PARAMS_SVH
`define SPO_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define SPO_ADDR_W 8
`define SPO_CFG2_ADDR 8'h88
`define SPO_CFG2_RESET 32'h0000_0000

// ****************************************************************
// Field positions inside the configuration word
// ****************************************************************
`define SPO_PARITY_BIT 31
`define SPO_PHASE_MSB 30
`define SPO_PHASE_LSB 29
`define SPO_DIV_MSB 28
`define SPO_DIV_LSB 25
`define SPO_STOPCFG_BIT 24
`define SPO_THR_MSB 23
`define SPO_THR_LSB 21

// ****************************************************************
// Division and threshold encodings
// ****************************************************************
`define SPO_DIV_ZERO_RATIO 4'h3
`define SPO_THR_MV_W 8
`define SPO_THR_CODE0_MV 8'h01
`define SPO_THR_CODE1_MV 8'h02
`define SPO_THR_CODE2_MV 8'h05
`define SPO_THR_CODE3_MV 8'h0a
`define SPO_THR_CODE4_MV 8'h14
`define SPO_THR_CODE5_MV 8'h1e

`endif

// ---- shared/spo_pkg.sv ----
package spo_pkg;

   // ****************************************************************
   // Phase select codes of the pulse output.
   // ****************************************************************
   typedef enum logic [1:0] {
      SPO_PHASE_BOTH = 2'h0,
      SPO_PHASE_CLOSED = 2'h1,
      SPO_PHASE_FIRST_TRY = 2'h2,
      SPO_PHASE_INVALID = 2'h3
   } spo_phase_e;

   // ****************************************************************
   // Output gating state, one-hot.
   // ****************************************************************
   typedef enum logic [2:0] {
      SPO_ST_IDLE = 3'b001,
      SPO_ST_RUN = 3'b010,
      SPO_ST_HALTED = 3'b100
   } spo_state_e;

   typedef logic [31:0] spo_word_t;

endpackage

// ---- verilog/spo_divider.sv ----
`timescale 1ns/1ps

// Divides a stream of one-cycle events by a programmable ratio.
module spo_divider #(
   parameter int DIV_W = 4
) (
   input wire logic clk_sys, // System clock.
   input wire logic reset, // Asynchronous reset, active high.
   input wire logic clear, // Restarts the count.
   input wire logic evt, // One-cycle input event.
   input wire logic [DIV_W-1:0] ratio, // Division ratio, never zero.
   output logic tick // One-cycle pulse per ratio events.
);

   logic [DIV_W-1:0] count_ff;
   logic [DIV_W-1:0] nxt_count;
   logic tick_ff;
   logic nxt_tick;
   wire logic last_evt;

   // ****************************************************************
   // Counting
   // ****************************************************************

   // The last event of a group restarts the count and fires the tick.
   assign last_evt = evt && (count_ff >= ratio - DIV_W'(1));
   assign nxt_count = clear ? '0 : (last_evt ? '0 : (evt ? count_ff + DIV_W'(1) : count_ff));
   assign nxt_tick = !clear && last_evt;

   // Registered so that the tick is a clean flip-flop output.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         count_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;

endmodule

// ---- test/spo_core_props.sv ----
`timescale 1ns/1ps
`include "spo_params.svh"

// ****************************************************************
// Port checks of the pulse output core.
// ****************************************************************
module spo_core_props (
   input wire logic clk_sys, // Clock.
   input wire logic reset, // Async reset.
   input wire logic [7:0] reg_addr, // Address.
   input wire logic reg_wr, // Write strobe.
   input wire logic [31:0] reg_wdata, // Write data.
   input wire logic reg_rd, // Read strobe.
   input wire spo_pkg::spo_word_t reg_rdata, // Read data.
   input wire logic comm_evt, // Commutation event.
   input wire logic open_loop_active, // Open loop.
   input wire logic closed_loop_active, // Closed loop.
   input wire logic first_try, // First attempt.
   input wire logic motor_driven, // Motor driven.
   input wire logic speed_pulse_output, // Pulse output.
   input wire logic [1:0] pulse_phase_select, // Live phase field.
   input wire logic pulse_stop_active // Halted on back-EMF.
);
   import spo_pkg::*;
   spo_word_t cfg_ff;
   wire hit = reg_addr == `SPO_CFG2_ADDR;
   // Shadow word; it follows only writes to the mapped address, so a stray write shows.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cfg_ff <= `SPO_CFG2_RESET;
      end else if (reg_wr && hit) begin
         cfg_ff <= reg_wdata;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_read_data: assert property (reg_rd && hit |=> reg_rdata == $past(cfg_ff))
      else $error("read data differs from stored word");
   a_read_unmapped: assert property (reg_rd && !hit |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_phase_field: assert property (pulse_phase_select == cfg_ff[30:29])
      else $error("phase field differs from stored word");
   a_closed_only: assert property (pulse_phase_select == 2'h1 && !closed_loop_active |=> !speed_pulse_output)
      else $error("pulse outside closed loop");
   a_first_try_gate: assert property (pulse_phase_select == 2'h2 && !closed_loop_active
      && !(open_loop_active && first_try) |=> !speed_pulse_output)
      else $error("pulse in open loop after first try");
   a_invalid_quiet: assert property (pulse_phase_select == 2'h3 |=> !speed_pulse_output)
      else $error("pulse with invalid phase code");
   a_halt_quiet: assert property (pulse_stop_active |=> !speed_pulse_output)
      else $error("pulse while halted");
   a_halt_cause: assert property ($rose(pulse_stop_active) |-> !$past(cfg_ff[24]))
      else $error("halt with stop bit set");
   // The state leaves RUN one edge after the drive drops and the output falls one edge later.
   a_idle_quiet: assert property (!motor_driven |-> ##2 !speed_pulse_output)
      else $error("pulse while not driven");
   a_toggle_cause: assert property ($rose(speed_pulse_output) |-> $past(comm_evt, 2))
      else $error("pulse edge without event");
   c_pulse: cover property ($rose(speed_pulse_output));
   c_halt: cover property ($rose(pulse_stop_active));
   c_unmapped: cover property (reg_rd && !hit);
endmodule

// ---- test/spo_core_tb_top.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Register and pulse path tests of the core.
// ****************************************************************
module spo_core_tb_top;
   import spo_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_rd = 1'b0;
   spo_word_t reg_rdata;
   logic comm_evt = 1'b0, open_loop_active = 1'b0, closed_loop_active = 1'b0;
   logic first_try = 1'b0, motor_driven = 1'b0, prev_out = 1'b0;
   logic [7:0] bemf_mv = 8'h00;
   logic speed_pulse_output, pulse_stop_active;
   logic [1:0] pulse_phase_select;
   int toggles = 0, miscompares = 0, n_compared = 0;
   always #4 clk_sys = ~clk_sys;
   spo_core u_dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comm_evt(comm_evt),
      .open_loop_active(open_loop_active), .closed_loop_active(closed_loop_active),
      .first_try(first_try), .motor_driven(motor_driven), .bemf_mv(bemf_mv),
      .speed_pulse_output(speed_pulse_output), .pulse_phase_select(pulse_phase_select),
      .pulse_stop_active(pulse_stop_active));
   // Output edges are counted on the falling edge, where the output has settled.
   always @(negedge clk_sys) begin
      toggles += int'(speed_pulse_output !== prev_out);
      prev_out = speed_pulse_output;
   end
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] exp);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      @(negedge clk_sys);
      check("read data", reg_rdata, exp);
   endtask
   function automatic logic [31:0] word(logic [1:0] ph, logic [3:0] dv, logic st, logic [2:0] th);
      return {1'b0, ph, dv, st, th, 21'h0};
   endfunction
   // One drive episode; dropping the drive afterwards clears the divider for the next one.
   task automatic run(logic [31:0] w, logic [2:0] lp, logic [7:0] bemf, int nev, int exp_t,
         logic exp_s);
      wr(8'h88, w);
      {open_loop_active, closed_loop_active, first_try} = lp;
      bemf_mv = bemf;
      motor_driven = 1'b1;
      repeat (3) @(negedge clk_sys);
      toggles = 0;
      repeat (nev) begin
         comm_evt = 1'b1;
         @(negedge clk_sys);
      end
      comm_evt = 1'b0;
      repeat (4) @(negedge clk_sys);
      check("toggles", toggles, exp_t);
      check("halted", pulse_stop_active, exp_s);
      motor_driven = 1'b0;
      repeat (3) @(negedge clk_sys);
   endtask
   task automatic test_done();
      if (miscompares == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Main sequence.
   initial begin
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      reset = 1'b0;
      rd(8'h88, 32'h0);
      wr(8'h88, 32'ha5c3_96f1);
      rd(8'h88, 32'ha5c3_96f1);
      check("phase field", pulse_phase_select, 32'h0000_0001);
      wr(8'h8c, 32'hffff_ffff);
      rd(8'h88, 32'ha5c3_96f1);
      rd(8'h8c, 32'h0);
      for (int c = 0; c < 16; c++) begin
         run(word(2'h0, c[3:0], 1'b1, 3'h0), 3'b010, 8'h00, 30, 30 / (c == 0 ? 3 : c), 1'b0);
      end
      run(word(2'h0, 4'h1, 1'b1, 3'h0), 3'b100, 8'h00, 4, 4, 1'b0);
      run(word(2'h0, 4'h1, 1'b1, 3'h0), 3'b010, 8'h00, 4, 4, 1'b0);
      run(word(2'h1, 4'h1, 1'b1, 3'h0), 3'b100, 8'h00, 4, 0, 1'b0);
      run(word(2'h1, 4'h1, 1'b1, 3'h0), 3'b010, 8'h00, 4, 4, 1'b0);
      run(word(2'h2, 4'h1, 1'b1, 3'h0), 3'b101, 8'h00, 4, 4, 1'b0);
      run(word(2'h2, 4'h1, 1'b1, 3'h0), 3'b100, 8'h00, 4, 0, 1'b0);
      run(word(2'h2, 4'h1, 1'b1, 3'h0), 3'b010, 8'h00, 4, 4, 1'b0);
      run(word(2'h3, 4'h1, 1'b1, 3'h0), 3'b010, 8'h00, 4, 0, 1'b0);
      run(word(2'h0, 4'h1, 1'b0, 3'h0), 3'b010, 8'h00, 4, 0, 1'b1);
      run(word(2'h0, 4'h1, 1'b0, 3'h2), 3'b010, 8'h05, 4, 4, 1'b0);
      run(word(2'h0, 4'h1, 1'b0, 3'h5), 3'b010, 8'h1d, 4, 0, 1'b1);
      run(word(2'h0, 4'h1, 1'b1, 3'h0), 3'b010, 8'h00, 4, 4, 1'b0);
      test_done();
   end
   // Watchdog, several times the expected run length.
   initial begin
      #50us;
      miscompares++;
      test_done();
   end
endmodule

bind spo_core spo_core_props u_props (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .comm_evt(comm_evt), .open_loop_active(open_loop_active),
   .closed_loop_active(closed_loop_active), .first_try(first_try),
   .motor_driven(motor_driven), .speed_pulse_output(speed_pulse_output),
   .pulse_phase_select(pulse_phase_select), .pulse_stop_active(pulse_stop_active));
